//--- scsi_host_regs.svh
// constants of the scsi register-port host: offsets, fields, timing
// assumes inclusion from package and modules by its bare name
`ifndef SCSI_HOST_REGS_SVH
`define SCSI_HOST_REGS_SVH

// ====================================================================
// own register port
`define OFS_CTRL 3'h0
`define OFS_WDATA 3'h1
`define OFS_STATUS 3'h2
`define OFS_RDATA 3'h3
`define OFS_MODE_SHADOW 3'h4
`define CTRL_READ_BIT 3
`define CTRL_DMA_BIT 4
`define CTRL_EOP_BIT 5
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_REFUSED_BIT 2
`define ST_DRQ_BIT 3
`define ST_IRQ_BIT 4
`define ST_READY_BIT 5
`define ST_DMA_GRANT_N_BIT 6
`define RESET_BYTE 8'h00

// ====================================================================
// device register map
`define DEV_DATA_REG 3'h0
`define DEV_CMD_REG 3'h1
`define DEV_MODE_REG 3'h2
`define DEV_SEND_DMA 3'h5
`define DEV_TRECV_DMA 3'h6
`define DEV_IRECV_DMA 3'h7
`define CMD_DRIVE_DATA 0
`define CMD_LOST_ARB 5
`define CMD_BUS_RST 7
`define MODE_ARB 0
`define MODE_DMA 1
`define MODE_TARGET 6
`define MODE_BLOCK 7

// ====================================================================
// bus cycle timing at the system clock
`define SYS_CLK_MHZ 20
`define ADDR_SETUP_NS 50
`define STROBE_NS 200
`define DATA_HOLD_NS 50
`define SETUP_CYC ((`ADDR_SETUP_NS * `SYS_CLK_MHZ + 999) / 1000)
`define STROBE_CYC ((`STROBE_NS * `SYS_CLK_MHZ + 999) / 1000)
`define HOLD_CYC ((`DATA_HOLD_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

//--- scsi_host_pkg.sv
// types shared by the scsi register-port host
// assumes scsi_host_regs.svh beside it
`default_nettype none
`include "scsi_host_regs.svh"

package scsi_host_pkg;
    // ================================================================
    // cycle engine states
    typedef enum logic [1:0] {
        CYC_IDLE = 2'b00,
        CYC_SETUP = 2'b01,
        CYC_STROBE = 2'b10,
        CYC_HOLD = 2'b11
    } cyc_state_e;

    typedef logic [7:0] byte_t;

    function automatic logic is_onehot(input byte_t v);
        return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
    endfunction
endpackage

`default_nettype wire

//--- dev_cycle_if.sv
// carrier between the host control logic and its bus cycle engine
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none

interface dev_cycle_if;
    logic start;
    logic [2:0] addr;
    logic write;
    logic dma;
    logic eop;
    logic [7:0] wdata;
    logic hold_dma_grant_n;
    logic busy;
    logic done;
    logic dma_grant_n_held;
    logic [7:0] rdata;

    modport ctrl (
        output start, addr, write, dma, eop, wdata, hold_dma_grant_n,
        input busy, done, dma_grant_n_held, rdata
    );
    modport eng (
        input start, addr, write, dma, eop, wdata, hold_dma_grant_n,
        output busy, done, dma_grant_n_held, rdata
    );
endinterface

`default_nettype wire

//--- dev_cycle_engine.sv
// one asynchronous register or dma cycle on the device pins
// assumes data_in already synchronised, start only when not busy
`timescale 1ns/1ps
`default_nettype none
`include "scsi_host_regs.svh"

module dev_cycle_engine (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    dev_cycle_if.eng cyc,
    input wire logic [7:0] data_in,
    output logic [2:0] sel,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic dma_grant_n_n,
    output logic eop_n,
    output logic [7:0] data_o,
    output logic data_oe
);
    scsi_host_pkg::cyc_state_e state_q;
    logic [3:0] cnt_q;
    logic write_q;
    logic dma_q;
    logic eop_q;
    logic last_w;

    assign last_w = (cnt_q == 4'h0);
    assign cyc.busy = (state_q != scsi_host_pkg::CYC_IDLE);
    assign cyc.done = ce && last_w && (state_q == scsi_host_pkg::CYC_HOLD);
    assign cyc.dma_grant_n_held = !dma_grant_n_n;

    // ================================================================
    // sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= scsi_host_pkg::CYC_IDLE;
            cnt_q <= 4'h0;
            write_q <= 1'b0;
            dma_q <= 1'b0;
            eop_q <= 1'b0;
        end else if (ce) begin
            case (state_q)
                scsi_host_pkg::CYC_IDLE: begin
                    if (cyc.start) begin
                        state_q <= scsi_host_pkg::CYC_SETUP;
                        cnt_q <= 4'(`SETUP_CYC - 1);
                        write_q <= cyc.write;
                        dma_q <= cyc.dma;
                        eop_q <= cyc.eop;
                    end
                end
                scsi_host_pkg::CYC_SETUP: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (last_w) begin
                        state_q <= scsi_host_pkg::CYC_STROBE;
                        cnt_q <= 4'(`STROBE_CYC - 1);
                    end
                end
                scsi_host_pkg::CYC_STROBE: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (last_w) begin
                        state_q <= scsi_host_pkg::CYC_HOLD;
                        cnt_q <= 4'(`HOLD_CYC - 1);
                    end
                end
                scsi_host_pkg::CYC_HOLD: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (last_w) begin
                        state_q <= scsi_host_pkg::CYC_IDLE;
                    end
                end
                default: state_q <= scsi_host_pkg::CYC_IDLE;
            endcase
        end
    end

    // ================================================================
    // pins and captured read byte
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sel <= 3'h0;
            cs_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            dma_grant_n_n <= 1'b1;
            eop_n <= 1'b1;
            data_o <= `RESET_BYTE;
            data_oe <= 1'b0;
            cyc.rdata <= `RESET_BYTE;
        end else if (ce) begin
            case (state_q)
                scsi_host_pkg::CYC_IDLE: begin
                    if (cyc.start) begin
                        sel <= cyc.addr;
                        // grant replaces chip select, never both
                        if (cyc.dma) begin
                            dma_grant_n_n <= 1'b0;
                        end else begin
                            cs_n <= 1'b0;
                        end
                        data_o <= cyc.wdata;
                        data_oe <= cyc.write;
                    end else if (!cyc.hold_dma_grant_n) begin
                        dma_grant_n_n <= 1'b1;
                    end
                end
                scsi_host_pkg::CYC_SETUP: begin
                    if (last_w) begin
                        wr_n <= !write_q;
                        rd_n <= write_q;
                        // end of process rides the strobe of a dma byte
                        eop_n <= !(eop_q && dma_q);
                    end
                end
                scsi_host_pkg::CYC_STROBE: begin
                    if (last_w) begin
                        rd_n <= 1'b1;
                        wr_n <= 1'b1;
                        eop_n <= 1'b1;
                        // live bus byte at register 0 is read here
                        if (!write_q) begin
                            cyc.rdata <= data_in;
                        end
                    end
                end
                scsi_host_pkg::CYC_HOLD: begin
                    if (last_w) begin
                        cs_n <= 1'b1;
                        data_oe <= 1'b0;
                        // normal dma ends each byte on grant release
                        if (!(dma_q && cyc.hold_dma_grant_n)) begin
                            dma_grant_n_n <= 1'b1;
                        end
                    end
                end
                default: cs_n <= 1'b1;
            endcase
        end
    end

    // ================================================================
    // checks
    chk_strobe_width: assert property (@(posedge clk)
        disable iff (!rstn || !ce)
        $fell(rd_n && wr_n) |-> !(rd_n && wr_n) [*4] ##1 (rd_n && wr_n))
        else $error("strobe not four cycles wide");
    chk_dma_grant_n_normal: assert property (@(posedge clk)
        disable iff (!rstn || !ce)
        (cyc.done && dma_q && !cyc.hold_dma_grant_n) |=> dma_grant_n_n)
        else $error("grant kept after normal dma byte");
    cov_dma_byte: cover property (@(posedge clk) disable iff (!rstn)
        cyc.done && dma_q);
endmodule

`default_nettype wire

//--- scsi_host_ctrl.sv
// host controller driving a scsi bus chip through its register pins
// assumes a software port on SYS_CLK; device pins are asynchronous
// Operation
// - write bit 5 zero; reads lost arbitration
// - load one-hot own id before arbitrating
// - dma mode and role set before start-dma
// - normal dma ends on grant, block on strobe
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "scsi_host_regs.svh"

module scsi_host_ctrl (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic [2:0] REG_SELECT_LINES,
    output logic CS_N,
    output logic HOST_READ_STROBE_N,
    output logic HOST_WRITE_STROBE_N,
    output logic DMA_GRANT_N,
    output logic TRANSFER_END_N,
    input wire logic DMA_REQUEST_OUT,
    input wire logic DEV_IRQ,
    input wire logic DEV_READY,
    input wire logic [7:0] DEV_DATA_I,
    output logic [7:0] DEV_DATA_O,
    output logic DEV_DATA_OE
);
    dev_cycle_if cyc ();

    logic [10:0] sync1_q;
    logic [10:0] sync2_q;
    logic [7:0] data_s;
    logic drq_s;
    logic ready_s;
    logic irq_s;
    logic [5:0] ctrl_q;
    logic [7:0] wdata_q;
    logic [7:0] pend_data_q;
    logic pend_q;
    logic done_q;
    logic refused_q;
    logic [7:0] out_data_q;
    logic [7:0] cmd_q;
    logic [7:0] mode_q;
    logic busy_w;
    logic go_w;
    logic take_w;
    logic bad_w;
    logic [2:0] a_w;
    logic rd_w;
    logic [7:0] send_w;
    logic st_rd_w;

    // ================================================================
    // pin synchronisers, stage one read only by stage two
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sync1_q <= 11'h000;
            sync2_q <= 11'h000;
        end else if (CE) begin
            sync1_q <= {DEV_IRQ, DEV_READY, DMA_REQUEST_OUT, DEV_DATA_I};
            sync2_q <= sync1_q;
        end
    end
    assign data_s = sync2_q[7:0];
    assign drq_s = sync2_q[8];
    assign ready_s = sync2_q[9];
    assign irq_s = sync2_q[10];

    // ================================================================
    // order checks on a new device access
    assign a_w = WDATA[2:0];
    assign rd_w = WDATA[`CTRL_READ_BIT];
    assign busy_w = pend_q || cyc.busy;
    always_comb begin
        bad_w = 1'b0;
        if (!rd_w) begin
            case (a_w)
                // arbitration only with a single id bit loaded
                `DEV_MODE_REG: bad_w = wdata_q[`MODE_ARB] &&
                    !scsi_host_pkg::is_onehot(out_data_q);
                // dma send needs dma mode and data drive
                `DEV_SEND_DMA: bad_w = !(mode_q[`MODE_DMA] &&
                    cmd_q[`CMD_DRIVE_DATA]);
                // receive role must match the start register
                `DEV_TRECV_DMA: bad_w = !(mode_q[`MODE_DMA] &&
                    mode_q[`MODE_TARGET]);
                `DEV_IRECV_DMA: bad_w = !(mode_q[`MODE_DMA] &&
                    !mode_q[`MODE_TARGET]);
                default: bad_w = 1'b0;
            endcase
        end
    end
    assign take_w = CE && WR && (ADDR == `OFS_CTRL) && !busy_w && !bad_w;
    // the reserved command bit always goes out as zero
    assign send_w = (a_w == `DEV_CMD_REG) ?
        (wdata_q & ~(8'h01 << `CMD_LOST_ARB)) : wdata_q;

    // ================================================================
    // own registers and pending access
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q <= 6'h00;
            wdata_q <= `RESET_BYTE;
            pend_data_q <= `RESET_BYTE;
            pend_q <= 1'b0;
        end else if (CE) begin
            if (WR && (ADDR == `OFS_WDATA)) begin
                wdata_q <= WDATA;
            end
            if (take_w) begin
                ctrl_q <= WDATA[5:0];
                pend_data_q <= send_w;
                pend_q <= 1'b1;
            end else if (cyc.start) begin
                pend_q <= 1'b0;
            end
        end
    end

    // ================================================================
    // shadows of what the device was told
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            out_data_q <= `RESET_BYTE;
            cmd_q <= `RESET_BYTE;
            mode_q <= `RESET_BYTE;
        end else if (take_w && !rd_w) begin
            // byte for the bus, by cpu or dma write
            if (a_w == `DEV_DATA_REG) begin
                out_data_q <= wdata_q;
            end
            if (a_w == `DEV_CMD_REG) begin
                cmd_q <= send_w;
                // bus reset clears the chip's control state
                if (send_w[`CMD_BUS_RST]) begin
                    mode_q <= `RESET_BYTE;
                    cmd_q <= 8'h01 << `CMD_BUS_RST;
                end
            end
            if (a_w == `DEV_MODE_REG) begin
                mode_q <= wdata_q;
            end
        end
    end

    // ================================================================
    // cycle issue; dma bytes wait for the chip's request, or for its ready line in block mode
    always_comb begin
        if (ctrl_q[`CTRL_DMA_BIT]) begin
            go_w = mode_q[`MODE_BLOCK] ? ready_s : drq_s;
        end else begin
            go_w = !cyc.dma_grant_n_held;
        end
    end
    assign cyc.start = CE && pend_q && !cyc.busy && go_w;
    assign cyc.addr = ctrl_q[2:0];
    assign cyc.write = !ctrl_q[`CTRL_READ_BIT];
    assign cyc.dma = ctrl_q[`CTRL_DMA_BIT];
    assign cyc.eop = ctrl_q[`CTRL_EOP_BIT];
    assign cyc.wdata = pend_data_q;
    // block mode keeps the grant low between bytes
    assign cyc.hold_dma_grant_n = mode_q[`MODE_DMA] && mode_q[`MODE_BLOCK] &&
        !(pend_q && !ctrl_q[`CTRL_DMA_BIT]);

    dev_cycle_engine u_eng (
        .clk(SYS_CLK),
        .rstn(RSTN),
        .ce(CE),
        .cyc(cyc),
        .data_in(data_s),
        .sel(REG_SELECT_LINES),
        .cs_n(CS_N),
        .rd_n(HOST_READ_STROBE_N),
        .wr_n(HOST_WRITE_STROBE_N),
        .dma_grant_n_n(DMA_GRANT_N),
        .eop_n(TRANSFER_END_N),
        .data_o(DEV_DATA_O),
        .data_oe(DEV_DATA_OE)
    );

    // ================================================================
    // sticky flags, an event beats a clearing read
    assign st_rd_w = RD && (ADDR == `OFS_STATUS);
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            done_q <= 1'b0;
            refused_q <= 1'b0;
        end else if (CE) begin
            done_q <= cyc.done || (done_q && !st_rd_w);
            refused_q <= (WR && (ADDR == `OFS_CTRL) && (busy_w || bad_w)) ||
                (refused_q && !st_rd_w);
        end
    end

    // ================================================================
    // read port, data one cycle after the strobe
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= `RESET_BYTE;
        end else if (CE) begin
            RDATA <= `RESET_BYTE;
            if (RD) begin
                case (ADDR)
                    `OFS_CTRL: RDATA <= {2'b00, ctrl_q};
                    `OFS_WDATA: RDATA <= wdata_q;
                    `OFS_STATUS: RDATA <= {1'b0, cyc.dma_grant_n_held, ready_s,
                        irq_s, drq_s, refused_q, done_q, busy_w};
                    `OFS_RDATA: RDATA <= cyc.rdata;
                    `OFS_MODE_SHADOW: RDATA <= mode_q;
                    default: RDATA <= `RESET_BYTE;
                endcase
            end
        end
    end

    // ================================================================
    // checks
    chk_bit5_zero: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        (cyc.start && cyc.write && cyc.addr == `DEV_CMD_REG)
        |-> !cyc.wdata[`CMD_LOST_ARB])
        else $error("reserved command bit sent as one");
    chk_id_onehot: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        (cyc.start && cyc.write && cyc.addr == `DEV_MODE_REG &&
        cyc.wdata[`MODE_ARB]) |-> scsi_host_pkg::is_onehot(out_data_q))
        else $error("arbitration without one-hot id");
    chk_send_guard: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        (cyc.start && cyc.write && cyc.addr == `DEV_SEND_DMA)
        |-> (mode_q[`MODE_DMA] && cmd_q[`CMD_DRIVE_DATA]))
        else $error("dma send started unprepared");
    chk_recv_role: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        (cyc.start && cyc.write && (cyc.addr == `DEV_TRECV_DMA ||
        cyc.addr == `DEV_IRECV_DMA)) |-> (mode_q[`MODE_DMA] &&
        (mode_q[`MODE_TARGET] == (cyc.addr == `DEV_TRECV_DMA))))
        else $error("dma receive role mismatch");
    chk_cs_dma_grant_n_excl: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN)
        !(!CS_N && !DMA_GRANT_N))
        else $error("chip select and grant together");
    chk_refuse_busy: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN || !CE)
        (WR && ADDR == `OFS_CTRL && busy_w) |=> refused_q)
        else $error("busy access not flagged refused");
    chk_done_wins: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN || !CE)
        (cyc.done && st_rd_w) |=> done_q ##1 (RDATA[`ST_DONE_BIT] ||
        !$past(st_rd_w)))
        else $error("done lost against clearing read");
    chk_read_slot: assert property (@(posedge SYS_CLK)
        disable iff (!RSTN || !CE)
        (RD && ADDR == `OFS_MODE_SHADOW) |=> (RDATA == $past(mode_q)))
        else $error("read data not in next cycle");
    cov_reg_read: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        cyc.start && !cyc.write);
    cov_refused: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        WR && ADDR == `OFS_CTRL && bad_w);
    cov_block_hold: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        cyc.done ##1 !DMA_GRANT_N [*3]);
endmodule

`default_nettype wire

//--- scsi_dev_model.sv
// behavioural model of the bus chip seen through its register pins
// assumes host strobes active low; data bus split into in, out, enable
`timescale 1ns/1ps
`default_nettype none

module scsi_dev_model #(
    parameter logic [7:0] LIVE = 8'h3c
) (
    input wire logic rstn,
    input wire logic [2:0] sel,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic dma_grant_n_n,
    input wire logic eop_n,
    input wire logic [7:0] din,
    input wire logic oe,
    output logic [7:0] dout,
    output logic dma_request_out,
    output logic irq,
    output logic ready
);
    // ================================================================
    // registers
    logic [7:0] out_q, cmd_q, mode_q, last_q, rv;
    logic irq_q;
    always @(posedge wr_n or negedge rstn) begin
        if (!rstn) begin
            out_q <= 8'h00;
            cmd_q <= 8'h00;
            mode_q <= 8'h00;
            irq_q <= 1'b0;
        end else if (!dma_grant_n_n) begin
            out_q <= din;
        end else if (!cs_n) begin
            case (sel)
                3'h0: out_q <= din;
                3'h1: begin
                    if (din[7]) begin
                        cmd_q <= 8'h80;
                        mode_q <= 8'h00;
                        out_q <= 8'h00;
                        irq_q <= 1'b1;
                    end else begin
                        cmd_q <= {1'b0, din[6:0]};
                    end
                end
                3'h2: mode_q <= din;
                default: ;
            endcase
        end
    end
    // ================================================================
    // read side; idle bus shows inverse of last byte, never a stale copy
    always_comb begin
        case (sel)
            3'h0: rv = LIVE;
            3'h1: rv = {cmd_q[7], mode_q[0], 1'b0, cmd_q[4:0]};
            3'h2: rv = mode_q;
            default: rv = 8'h00;
        endcase
    end
    always @(posedge rd_n or negedge rstn) begin
        if (!rstn) last_q <= 8'h00;
        else last_q <= rv;
    end
    // ================================================================
    // scsi side byte and parity; test mode drops every driver
    logic [7:0] bus_db;
    logic bus_par, eop_q;
    assign bus_db = (cmd_q[0] && !cmd_q[6]) ? out_q : 8'h00;
    assign bus_par = cmd_q[0] && !cmd_q[6] && !(^out_q);
    always @(negedge eop_n or negedge rstn) begin
        if (!rstn) eop_q <= 1'b0;
        else if (mode_q[3]) eop_q <= 1'b1;
    end
    assign dout = oe ? din :
        ((!rd_n && (!cs_n || !dma_grant_n_n)) ? rv : ~last_q);
    assign dma_request_out = mode_q[1] & dma_grant_n_n;
    assign ready = mode_q[1] & mode_q[7];
    assign irq = irq_q | eop_q;
endmodule

`default_nettype wire

//--- scsi_host_ctrl_tb.sv
// self-checking bench for the scsi register-port host
// assumes scsi_dev_model on the device pins
`timescale 1ns/1ps
`default_nettype none

module scsi_host_ctrl_tb;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, dout, din, s;
    logic [2:0] sel;
    logic cs_n, rd_n, wr_n, dma_grant_n_n, eop_n, oe, dma_request_out, irq, rdy;
    int n_fail = 0;
    int total_checks = 0;
    always #25 clk = ~clk;

    scsi_host_ctrl dut (.SYS_CLK(clk), .RSTN(rstn), .CE(1'b1),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .REG_SELECT_LINES(sel), .CS_N(cs_n), .HOST_READ_STROBE_N(rd_n),
        .HOST_WRITE_STROBE_N(wr_n), .DMA_GRANT_N(dma_grant_n_n),
        .TRANSFER_END_N(eop_n), .DMA_REQUEST_OUT(dma_request_out), .DEV_IRQ(irq),
        .DEV_READY(rdy), .DEV_DATA_I(din), .DEV_DATA_O(dout),
        .DEV_DATA_OE(oe));
    scsi_dev_model m (.rstn(rstn), .sel(sel), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .dma_grant_n_n(dma_grant_n_n), .eop_n(eop_n),
        .din(dout), .oe(oe), .dout(din),
        .dma_request_out(dma_request_out), .irq(irq), .ready(rdy));

    // ================================================================
    // bus tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // launch one device access; first status read kept for refusals
    task automatic dev(input logic [7:0] ctl, input logic [7:0] d,
                       output logic [7:0] st);
        logic [7:0] p;
        wr_reg(3'h1, d);
        wr_reg(3'h0, ctl);
        rd_reg(3'h2, st);
        repeat (3) @(posedge clk);
        for (int i = 0; i < 20; i++) begin
            rd_reg(3'h2, p);
            if (p[0] === 1'b0) break;
        end
    endtask

    // ================================================================
    // scenarios
    task automatic t_reset;
        chk({4'h0, cs_n, rd_n, wr_n, oe}, 8'h0e);
        rd_reg(3'h7, s);
        chk(s, 8'h00);
        rd_reg(3'h2, s);
        chk(s, 8'h00);
    endtask
    task automatic t_mode_cmd;
        dev(8'h02, 8'h42, s);
        chk(m.mode_q, 8'h42);
        rd_reg(3'h4, s);
        chk(s, 8'h42);
        dev(8'h01, 8'h2e, s);
        chk(m.cmd_q, 8'h0e);
        dev(8'h09, 8'h00, s);
        rd_reg(3'h3, s);
        chk(s, 8'h0e);
        dev(8'h08, 8'h00, s);
        rd_reg(3'h3, s);
        chk(s, 8'h3c);
    endtask
    task automatic t_arb;
        dev(8'h00, 8'h03, s);
        dev(8'h02, 8'h01, s);
        chk({7'h0, s[2]}, 8'h01);
        chk(m.mode_q, 8'h42);
        dev(8'h00, 8'h40, s);
        dev(8'h02, 8'h01, s);
        chk({7'h0, s[2]}, 8'h00);
        dev(8'h09, 8'h00, s);
        rd_reg(3'h3, s);
        chk({7'h0, s[6]}, 8'h01);
    endtask
    task automatic t_dma;
        dev(8'h05, 8'h00, s);
        chk({7'h0, s[2]}, 8'h01);
        dev(8'h02, 8'h02, s);
        dev(8'h06, 8'h00, s);
        chk({7'h0, s[2]}, 8'h01);
        dev(8'h07, 8'h00, s);
        chk({7'h0, s[2]}, 8'h00);
        dev(8'h30, 8'h5a, s);
        chk(m.out_q, 8'h5a);
        rd_reg(3'h2, s);
        chk({7'h0, s[4]}, 8'h00);
        dev(8'h02, 8'h8a, s);
        dev(8'h30, 8'ha5, s);
        chk(m.out_q, 8'ha5);
        rd_reg(3'h2, s);
        chk({1'b0, s[6], 1'b0, s[4], 4'h0}, 8'h50);
        dev(8'h02, 8'h00, s);
        chk({7'h0, dma_grant_n_n}, 8'h01);
        chk(m.mode_q, 8'h00);
        dev(8'h01, 8'h01, s);
        chk(m.bus_db, 8'ha5);
        chk({7'h0, m.bus_par}, 8'h01);
        dev(8'h01, 8'h41, s);
        chk({m.bus_db[7:1], m.bus_par}, 8'h00);
    endtask
    task automatic t_bus_rst;
        dev(8'h02, 8'h42, s);
        dev(8'h01, 8'h80, s);
        chk(m.cmd_q, 8'h80);
        rd_reg(3'h4, s);
        chk(s, 8'h00);
        rd_reg(3'h2, s);
        chk({7'h0, s[4]}, 8'h01);
    endtask

    task automatic give_verdict;
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_mode_cmd();
        t_arb();
        t_dma();
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_bus_rst();
        give_verdict();
    end
    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
endmodule

`default_nettype wire
